// >>> src/overload_timing_regs.vh
// register offsets, field positions, reset values and timing counts for the overload shutdown timers
`ifndef OVERLOAD_TIMING_REGS_VH
`define OVERLOAD_TIMING_REGS_VH

// register offsets (8-bit address space)
`define OFS_SUPPLY_LIMIT_ACTIVE_TIMING 8'h9d
`define OFS_SUPPLY_OVERCURRENT_TIMING  8'h9e
`define OFS_LINE_OVERCURRENT_TIMING    8'h9f
`define OFS_CHANNEL_STATUS             8'ha0
`define OFS_CHANNEL_REENABLE           8'ha1

// field positions
`define FLD_SCALE_BIT   7
`define FLD_BASE_HI     6
`define FLD_BASE_LO     5
`define FLD_TIME_MULTIPLIER_HI     4
`define FLD_TIME_MULTIPLIER_LO     0

// reset value of each timing register: scale 10, base 100 us, multiplier 1
`define TIMING_RESET    8'h21

// disable-time scale factors
`define SCALE_LOW       7'd10
`define SCALE_HIGH      7'd100

// time bases in microseconds
`define BASE0_US        20
`define BASE1_US        100
`define BASE2_US        1000
`define BASE3_US        10000

// time bases counted in 20 us ticks, sized for the timer's base counter
`define BASE0_TICKS     10'd1
`define BASE1_TICKS     10'd5
`define BASE2_TICKS     10'd50
`define BASE3_TICKS     10'd500

// clock rate and derived ticks per base unit (20 us)
`define CLK_MHZ         10
`define TICK_US         20
`define TICK_CYCLES     (`TICK_US * `CLK_MHZ)

`endif

// >>> src/overload_timer.v
// one condition timer: detection count then disable hold, counted in 20 us ticks
`timescale 1ns/100ps
module overload_timer (
    // clock and reset
    input  wire        clk,
    input  wire        rstnSync,
    // timing
    input  wire        tick,
    input  wire [7:0]  timing,
    // condition and control
    input  wire        fault,
    input  wire        reEnable,
    // results
    output reg         shutDown,
    output reg         holding
);
`include "overload_timing_regs.vh"

    localparam [2:0] ST_WATCH = 3'b001;
    localparam [2:0] ST_HOLD  = 3'b010;
    localparam [2:0] ST_OFF   = 3'b100;

    // ticks of 20 us per base code
    function [9:0] baseTicks;
        input [1:0] code;
        begin
            case (code)
                2'b00:   baseTicks = `BASE0_TICKS;
                2'b01:   baseTicks = `BASE1_TICKS;
                2'b10:   baseTicks = `BASE2_TICKS;
                default: baseTicks = `BASE3_TICKS;
            endcase
        end
    endfunction

    wire [4:0]  time_multiplier   = timing[`FLD_TIME_MULTIPLIER_HI:`FLD_TIME_MULTIPLIER_LO];
    wire [1:0]  base   = timing[`FLD_BASE_HI:`FLD_BASE_LO];
    wire [6:0]  scale  = timing[`FLD_SCALE_BIT] ? `SCALE_HIGH : `SCALE_LOW;
    wire [14:0] detTicks = baseTicks(base) * time_multiplier;
    wire [21:0] offTicks = detTicks * scale;

    reg [2:0]  state_q;
    reg [21:0] count_q;

    // detection runs only while the fault persists; a glitch restarts the count
    always @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            state_q  <= ST_WATCH;
            count_q  <= 22'h000000;
            shutDown <= 1'b0;
            holding  <= 1'b0;
        end else begin
            case (state_q)
                ST_WATCH: begin
                    if (!fault || time_multiplier == 5'h00) begin
                        count_q <= 22'h000000;
                    end else if (tick) begin
                        if (count_q + 22'h000001 >= {7'h00, detTicks}) begin
                            state_q  <= ST_HOLD;
                            shutDown <= 1'b1;
                            holding  <= 1'b1;
                            count_q  <= 22'h000000;
                        end else begin
                            count_q <= count_q + 22'h000001;
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick) begin
                        if (count_q + 22'h000001 >= offTicks) begin
                            state_q <= ST_OFF;
                            holding <= 1'b0;
                        end else begin
                            count_q <= count_q + 22'h000001;
                        end
                    end
                end
                ST_OFF: begin
                    // stays off until software re-enables after the hold
                    if (reEnable) begin
                        state_q  <= ST_WATCH;
                        shutDown <= 1'b0;
                        count_q  <= 22'h000000;
                    end
                end
                default: begin
                    state_q  <= ST_WATCH;
                    shutDown <= 1'b0;
                    holding  <= 1'b0;
                    count_q  <= 22'h000000;
                end
            endcase
        end
    end
endmodule

// >>> src/channel_overload_shutdown_timing.v
// top of the overload shutdown timing block: register port, fault sync, three timers per channel
// Function
// - the limit-active timer uses bit 7 to pick a disable scale of 10 (0) or 100 (1).
// - the limit-active timer takes its base from bits 6:5 as 20 us, 100 us, 1 ms or 10 ms.
// - the limit-active timer multiplier is bits 4:0, with zero turning automatic shutdown off.
// - limit-active detect time is base times multiplier and its off time is that times the scale.
// - supply overcurrent detect time is its own base times its own 5-bit multiplier, zero disables.
// - supply overcurrent base comes from bits 6:5 with the same four codes.
// - supply overcurrent bit 7 picks a disable scale of 10 or 100.
// - supply overcurrent off time is its detect time times its scale.
// - line overcurrent detect time is base times a 5-bit multiplier, zero disables.
// - line overcurrent off time is detect time times the scale from bit 7.
// - line overcurrent base comes from bits 6:5 and resets to code 01.
`timescale 1ns/100ps
module channel_overload_shutdown_timing #(
    parameter CHANNELS = 4
) (
    // clock and reset
    input  wire                  core_clk,
    input  wire                  rstn,
    // register port
    input  wire [7:0]            addr,
    input  wire [7:0]            wrData,
    input  wire                  wrStrobe,
    input  wire                  rdStrobe,
    output reg  [7:0]            rdData,
    // fault sensors per channel, asynchronous
    input  wire [CHANNELS-1:0]   supplyLimitActive,
    input  wire [CHANNELS-1:0]   supplyOvercurrent,
    input  wire [CHANNELS-1:0]   lineOvercurrent,
    // shutdown outputs per channel
    output reg  [CHANNELS-1:0]   supplyOff,
    output reg  [CHANNELS-1:0]   lineOff
);
`include "overload_timing_regs.vh"

    // reset release synchroniser
    reg rstMeta_q;
    reg rstnSync;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstnSync  <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstnSync  <= rstMeta_q;
        end
    end

    // 20 us tick divider; all base codes are whole multiples of it
    localparam integer TICK_END  = `TICK_CYCLES - 1;
    localparam [11:0]  TICK_LAST = TICK_END[11:0];
    reg [11:0] div_q;
    reg        tick_q;
    always @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            div_q  <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == TICK_LAST);
            div_q  <= (div_q == TICK_LAST) ? 12'h000 : div_q + 12'h001;
        end
    end

    // timing registers
    reg [7:0] limitTiming_q;
    reg [7:0] ovcTiming_q;
    reg [7:0] lineTiming_q;
    reg [CHANNELS-1:0] reEnable_q;   // one-cycle pulse per channel
    always @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            limitTiming_q <= `TIMING_RESET;
            ovcTiming_q   <= `TIMING_RESET;
            lineTiming_q  <= `TIMING_RESET;
            reEnable_q    <= {CHANNELS{1'b0}};
        end else begin
            reEnable_q <= {CHANNELS{1'b0}};
            if (wrStrobe) begin
                case (addr)
                    `OFS_SUPPLY_LIMIT_ACTIVE_TIMING: limitTiming_q <= wrData;
                    `OFS_SUPPLY_OVERCURRENT_TIMING:  ovcTiming_q   <= wrData;
                    `OFS_LINE_OVERCURRENT_TIMING:    lineTiming_q  <= wrData;
                    `OFS_CHANNEL_REENABLE:           reEnable_q    <= wrData[CHANNELS-1:0];
                    default: ;
                endcase
            end
        end
    end

    // fault inputs pass two flip-flops before the timers see them
    reg [3*CHANNELS-1:0] faultMeta_q;
    reg [3*CHANNELS-1:0] faultSync_q;
    always @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            faultMeta_q <= {3*CHANNELS{1'b0}};
            faultSync_q <= {3*CHANNELS{1'b0}};
        end else begin
            faultMeta_q <= {lineOvercurrent, supplyOvercurrent, supplyLimitActive};
            faultSync_q <= faultMeta_q;
        end
    end

    // three timers per channel: limit-active, supply overcurrent, line overcurrent
    // hold state stays inside each timer; only the shutdown level leaves it
    wire [3*CHANNELS-1:0] timerOff;
    genvar g;
    generate
        for (g = 0; g < 3*CHANNELS; g = g + 1) begin : gTimer
            wire [7:0] cfg = (g < CHANNELS) ? limitTiming_q :
                             (g < 2*CHANNELS) ? ovcTiming_q : lineTiming_q;
            overload_timer uTimer (
                .clk      (core_clk),
                .rstnSync (rstnSync),
                .tick     (tick_q),
                .timing   (cfg),
                .fault    (faultSync_q[g]),
                .reEnable (reEnable_q[g % CHANNELS]),
                .shutDown (timerOff[g]),
                .holding  ()
            );
        end
    endgenerate

    // registered shutdown outputs; supply switch opens on either supply condition
    always @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            supplyOff <= {CHANNELS{1'b0}};
            lineOff   <= {CHANNELS{1'b0}};
        end else begin
            supplyOff <= timerOff[CHANNELS-1:0] | timerOff[2*CHANNELS-1:CHANNELS];
            lineOff   <= timerOff[3*CHANNELS-1:2*CHANNELS];
        end
    end

    // read data valid the cycle after the strobe, zero otherwise and for unmapped addresses
    always @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            case (addr)
                `OFS_SUPPLY_LIMIT_ACTIVE_TIMING: rdData <= limitTiming_q;
                `OFS_SUPPLY_OVERCURRENT_TIMING:  rdData <= ovcTiming_q;
                `OFS_LINE_OVERCURRENT_TIMING:    rdData <= lineTiming_q;
                `OFS_CHANNEL_STATUS:             rdData <= {supplyOff, lineOff};
                default:                         rdData <= 8'h00;
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end
endmodule

// >>> bench/channel_overload_shutdown_timing_chk.sv
// checker for the overload shutdown timing block
`timescale 1ns/100ps
`include "overload_timing_regs.vh"
module channel_overload_shutdown_timing_chk #(parameter CHANNELS = 4) (
    // clock and reset
    input wire                core_clk,
    input wire                rstn,
    // register port
    input wire [7:0]          addr,
    input wire [7:0]          wrData,
    input wire                wrStrobe,
    input wire                rdStrobe,
    input wire [7:0]          rdData,
    // faults and shutdowns
    input wire [CHANNELS-1:0] supplyLimitActive,
    input wire [CHANNELS-1:0] supplyOvercurrent,
    input wire [CHANNELS-1:0] lineOvercurrent,
    input wire [CHANNELS-1:0] supplyOff,
    input wire [CHANNELS-1:0] lineOff
);
    reg [7:0] limT_q;
    reg [7:0] ovcT_q;
    reg [7:0] lineT_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // shadow of the timing registers, so read data can be judged
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {limT_q, ovcT_q, lineT_q} <= {3{`TIMING_RESET}};
        end else if (wrStrobe) begin
            if (addr == `OFS_SUPPLY_LIMIT_ACTIVE_TIMING) limT_q <= wrData;
            if (addr == `OFS_SUPPLY_OVERCURRENT_TIMING) ovcT_q <= wrData;
            if (addr == `OFS_LINE_OVERCURRENT_TIMING) lineT_q <= wrData;
        end
    end
    a_limit_read: assert property (rdStrobe && addr == `OFS_SUPPLY_LIMIT_ACTIVE_TIMING |=> rdData == $past(limT_q))
        else $error("limit timing read wrong");
    a_ovc_read: assert property (rdStrobe && addr == `OFS_SUPPLY_OVERCURRENT_TIMING |=> rdData == $past(ovcT_q))
        else $error("overcurrent timing read wrong");
    a_line_read: assert property (rdStrobe && addr == `OFS_LINE_OVERCURRENT_TIMING |=> rdData == $past(lineT_q))
        else $error("line timing read wrong");
    a_status_read: assert property (rdStrobe && addr == `OFS_CHANNEL_STATUS |=> rdData == {$past(supplyOff), $past(lineOff)})
        else $error("status read wrong");
    // a shutdown needs its fault seen through the two sync stages, the timer and the output flop
    a_line_cause: assert property ((lineOff & ~$past(lineOff) & ~$past(lineOvercurrent, 4)) == 0)
        else $error("line off without fault");
    a_supply_cause: assert property ((supplyOff & ~$past(supplyOff) & ~($past(supplyLimitActive, 4) | $past(supplyOvercurrent, 4))) == 0)
        else $error("supply off without fault");
    // the timer decided two edges earlier, with the multiplier it held then
    a_time_multiplier_zero: assert property (|(lineOff & ~$past(lineOff)) |-> ($past(lineT_q, 2) & 8'h1f) != 8'h00)
        else $error("line off with zero multiplier");
    // write pulse, timer leaves off, output flop: release shows three edges after the write
    a_off_release: assert property (|({$past(supplyOff), $past(lineOff)} & ~{supplyOff, lineOff}) |->
        $past(wrStrobe, 3) && $past(addr, 3) == `OFS_CHANNEL_REENABLE)
        else $error("off released without re-enable");
    c_line_trip: cover property ($rose(|lineOff));
    c_supply_trip: cover property ($rose(|supplyOff));
    c_release: cover property ($fell(|supplyOff));
endmodule
bind channel_overload_shutdown_timing channel_overload_shutdown_timing_chk #(.CHANNELS(CHANNELS)) chk (
    .core_clk(core_clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .supplyLimitActive(supplyLimitActive), .supplyOvercurrent(supplyOvercurrent),
    .lineOvercurrent(lineOvercurrent), .supplyOff(supplyOff), .lineOff(lineOff));

// >>> bench/field_device.sv
// field device model: fault levels per channel
`timescale 1ns/100ps
module field_device (
    // fault levels toward the block
    output logic [3:0] limitAct,
    output logic [3:0] overCur,
    output logic [3:0] lineOver
);
    initial {limitAct, overCur, lineOver} = 12'h000;
    // a fault is a level that stays until withdrawn
    task setFault(input int kind, input int ch, input logic v);
        case (kind)
            0: limitAct[ch] <= v;
            1: overCur[ch] <= v;
            default: lineOver[ch] <= v;
        endcase
    endtask
endmodule

// >>> bench/test_channel_overload_shutdown_timing.sv
// testbench for the overload shutdown timing block
`timescale 1ns/100ps
`include "overload_timing_regs.vh"
module test_channel_overload_shutdown_timing;
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic       wrStrobe = 1'b0;
    logic       rdStrobe = 1'b0;
    wire  [7:0] rdData;
    wire  [3:0] limitAct, overCur, lineOver, supplyOff, lineOff;
    int         bad_count = 0;
    int         compares = 0;
    int         cyc = 0;
    // 10 MHz clock and a cycle count for timing
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    field_device dev (.limitAct(limitAct), .overCur(overCur), .lineOver(lineOver));
    channel_overload_shutdown_timing uut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .supplyLimitActive(limitAct),
        .supplyOvercurrent(overCur), .lineOvercurrent(lineOver), .supplyOff(supplyOff), .lineOff(lineOff));
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task inRange(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) {addr, wrData, wrStrobe} <= {a, d, 1'b1};
        @(posedge core_clk) wrStrobe <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk) {addr, rdStrobe} <= {a, 1'b1};
        @(posedge core_clk) rdStrobe <= 1'b0;
        #1 compares++;
        if (rdData !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, rdData);
        end
    endtask
    function logic offBit(input int kind, input int ch);
        return (kind == 2) ? lineOff[ch] : supplyOff[ch];
    endfunction
    // time the trip, then retry re-enable; retries inside the hold must be ignored
    task trip(input int kind, input int ch, input int d, input int s);
        int t0;
        @(posedge core_clk) #1 t0 = cyc;
        dev.setFault(kind, ch, 1'b1);
        while (offBit(kind, ch) !== 1'b1 && cyc - t0 < d * 200 + 400) #100;
        inRange("detect cycles", (d - 1) * 200, d * 200 + 10, cyc - t0);
        if (offBit(kind, ch) !== 1'b1) print_verdict;
        t0 = cyc;
        rd(`OFS_CHANNEL_STATUS, (kind == 2) ? (8'h01 << ch) : (8'h10 << ch), "status");
        dev.setFault(kind, ch, 1'b0);
        while (offBit(kind, ch) === 1'b1 && cyc - t0 < d * s * 200 + 600) begin
            wr(`OFS_CHANNEL_REENABLE, 8'h01 << ch);
            repeat (20) @(posedge core_clk);
            #1;
        end
        inRange("hold cycles", d * s * 200 - 200, d * s * 200 + 300, cyc - t0);
        if (offBit(kind, ch) === 1'b1) print_verdict;
    endtask
    task resetValues;
        rd(`OFS_SUPPLY_LIMIT_ACTIVE_TIMING, `TIMING_RESET, "limit reset");
        rd(`OFS_SUPPLY_OVERCURRENT_TIMING, `TIMING_RESET, "overcurrent reset");
        rd(`OFS_LINE_OVERCURRENT_TIMING, `TIMING_RESET, "line reset");
        rd(8'h10, 8'h00, "unmapped");
    endtask
    // every field driven to its edge values; unmapped write has no effect
    task fieldsReadBack;
        wr(`OFS_SUPPLY_LIMIT_ACTIVE_TIMING, 8'he0);
        wr(`OFS_SUPPLY_OVERCURRENT_TIMING, 8'h9f);
        wr(`OFS_LINE_OVERCURRENT_TIMING, 8'h7f);
        wr(8'h10, 8'hff);
        rd(`OFS_SUPPLY_LIMIT_ACTIVE_TIMING, 8'he0, "limit fields");
        rd(`OFS_SUPPLY_OVERCURRENT_TIMING, 8'h9f, "overcurrent fields");
        rd(`OFS_LINE_OVERCURRENT_TIMING, 8'h7f, "line fields");
        rd(8'h10, 8'h00, "unmapped after write");
    endtask
    task limitTrip;
        wr(`OFS_SUPPLY_LIMIT_ACTIVE_TIMING, 8'h81);
        trip(0, 0, 1, 100);
    endtask
    task ovcTrip;
        wr(`OFS_SUPPLY_OVERCURRENT_TIMING, 8'h21);
        trip(1, 1, 5, 10);
    endtask
    task lineTrip;
        wr(`OFS_LINE_OVERCURRENT_TIMING, 8'h02);
        trip(2, 2, 2, 10);
    endtask
    task multZero;
        wr(`OFS_LINE_OVERCURRENT_TIMING, 8'h00);
        dev.setFault(2, 3, 1'b1);
        repeat (2000) @(posedge core_clk);
        #1 compares++;
        if (lineOff !== 4'h0) begin
            bad_count++;
            $display("mismatch line off with zero multiplier expected 0 seen %h", lineOff);
        end
        dev.setFault(2, 3, 1'b0);
    endtask
    // base code 10 detects after 1 ms; its 10 ms hold is left running at the end of the run
    task baseMsTrip;
        int t0;
        wr(`OFS_SUPPLY_LIMIT_ACTIVE_TIMING, 8'h41);
        @(posedge core_clk) #1 t0 = cyc;
        dev.setFault(0, 3, 1'b1);
        while (supplyOff[3] !== 1'b1 && cyc - t0 < 10400) #100;
        inRange("detect cycles base 1 ms", 9800, 10010, cyc - t0);
    endtask
    // reset for two cycles, first access on the fourth edge after release
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        resetValues;
        fieldsReadBack;
        limitTrip;
        ovcTrip;
        lineTrip;
        multZero;
        baseMsTrip;
        print_verdict;
    end
endmodule
